//--- mcrr_pkg.sv
// package of offsets, reset values and state codes for the reference readback bank
package mcrr_pkg;
   localparam int          ADDR_W   = 12;
   localparam int          DATA_W   = 32;
   localparam int          PHASE_W  = 16;
   localparam int          FRAC_W   = 27; // fixed point scale 2^27
   localparam int          NREG     = 8;
   localparam int          IRQ_W    = 4;
   // printed offsets, kept as indices; byte address is four times the index
   localparam logic [11:0] IDX_OL_SPEED   = 12'h53C;
   localparam logic [11:0] IDX_OL_TORQUE  = 12'h54C;
   localparam logic [11:0] IDX_CL_SPEED   = 12'h5D4;
   localparam logic [11:0] IDX_FLUX       = 12'h606;
   localparam logic [11:0] IDX_TORQUE     = 12'h608;
   localparam logic [11:0] IDX_SD_PHASE   = 12'h682;
   localparam logic [11:0] IDX_SD_SPEED   = 12'h68C;
   localparam logic [11:0] IDX_PD_PHASE   = 12'h6C0;
   // interrupt registers at chosen indices
   localparam logic [11:0] IDX_IRQ_STAT   = 12'h7F0;
   localparam logic [11:0] IDX_IRQ_EN     = 12'h7F1;
   localparam logic [11:0] IDX_IRQ_CLR    = 12'h7F2;
   localparam logic [13:0] ADDR_SHIFT_ZERO = 14'h0000;
   localparam logic [31:0] RST_WORD  = 32'h00000000;
   localparam logic [15:0] RST_PHASE = 16'h0000;
   localparam logic [3:0]  RST_IRQ   = 4'h0;
   localparam logic [31:0] UNMAPPED  = 32'h00000000;
   // interrupt status bit positions
   localparam int BIT_SD_DONE = 0;
   localparam int BIT_SD_ERR  = 1;
   localparam int BIT_PD_DONE = 2;
   localparam int BIT_PD_ERR  = 3;
   typedef enum logic [15:0] {
      MCRR_SD_INIT      = 16'h0000,
      MCRR_SD_STOP_CHK  = 16'h0001,
      MCRR_SD_EST_INIT  = 16'h0002,
      MCRR_SD_RUN_CHK   = 16'h0003,
      MCRR_SD_DIR_CHK   = 16'h0004,
      MCRR_SD_COMPLETE  = 16'h0005,
      MCRR_SD_FAULT     = 16'h0006
   } mcrr_sd_phase_t;
   typedef enum logic [15:0] {
      MCRR_PD_INIT      = 16'h0000,
      MCRR_PD_VEC_SETUP = 16'h0001,
      MCRR_PD_RUN       = 16'h0002,
      MCRR_PD_CLK_RISE  = 16'h0003,
      MCRR_PD_CLK_FALL  = 16'h0004,
      MCRR_PD_DECAY     = 16'h0005,
      MCRR_PD_TIMES     = 16'h0006,
      MCRR_PD_NEXT_VEC  = 16'h0007,
      MCRR_PD_SECTOR    = 16'h0008,
      MCRR_PD_POSITION  = 16'h0009,
      MCRR_PD_ANGLE     = 16'h000A,
      MCRR_PD_COMPLETE  = 16'h000B,
      MCRR_PD_FAULT     = 16'h000C
   } mcrr_pd_phase_t;
endpackage

//--- mcrr_upd_if.sv
// interface carrying internal value updates from the capture stage to the register bank
`timescale 1ns/100ps
interface mcrr_upd_if;
   logic [7:0]  we;    // one write enable per value slot
   logic [31:0] data [8];
   modport src (output we, output data);
   modport dst (input we, input data);
endinterface

//--- mcrr_capture.sv
// capture stage: takes engine values and phase codes and issues slot updates
`timescale 1ns/100ps
module mcrr_capture (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        eng_valid,
   input  wire logic [31:0] eng_ol_speed,
   input  wire logic [31:0] eng_ol_torque,
   input  wire logic [31:0] eng_cl_speed,
   input  wire logic [31:0] eng_flux,
   input  wire logic [31:0] eng_torque,
   input  wire logic [31:0] eng_sd_speed,
   input  wire logic [15:0] eng_sd_phase,
   input  wire logic [15:0] eng_pd_phase,
   mcrr_upd_if.src          upd
);
   logic [7:0]  we_ff,   nxt_we;
   logic [31:0] d_ff [8];
   logic [31:0] nxt_d [8];
   // register the engine values every cycle; all eight write enables follow the valid strobe
   always_comb begin
      nxt_we = {8{eng_valid}};
      nxt_d[0] = eng_ol_speed;
      nxt_d[1] = eng_ol_torque;
      nxt_d[2] = eng_cl_speed;
      nxt_d[3] = eng_flux;
      nxt_d[4] = eng_torque;
      nxt_d[5] = {16'h0000, eng_sd_phase};
      nxt_d[6] = eng_sd_speed;
      nxt_d[7] = {16'h0000, eng_pd_phase};
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         we_ff <= 8'h00;
         for (int i = 0; i < 8; i++) d_ff[i] <= mcrr_pkg::RST_WORD;
      end else begin
         we_ff <= nxt_we;
         for (int i = 0; i < 8; i++) d_ff[i] <= nxt_d[i];
      end
   end
   assign upd.we   = we_ff;
   assign upd.data = d_ff;
endmodule

//--- mcrr_irq.sv
// sticky event status with enable and write-one-to-clear
`timescale 1ns/100ps
module mcrr_irq (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] evt,
   input  wire logic [3:0] clr,
   input  wire logic       en_we,
   input  wire logic [3:0] en_wdata,
   output logic      [3:0] stat,
   output logic      [3:0] en,
   output logic            irq
);
   logic [3:0] stat_ff, nxt_stat, en_ff, nxt_en;
   logic       irq_ff,  nxt_irq;
   // set wins over clear
   always_comb begin
      nxt_stat = (stat_ff & ~clr) | evt;
      nxt_en   = en_we ? en_wdata : en_ff;
      nxt_irq  = |(nxt_stat & nxt_en);
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_ff <= mcrr_pkg::RST_IRQ;
         en_ff   <= mcrr_pkg::RST_IRQ;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         en_ff   <= nxt_en;
         irq_ff  <= nxt_irq;
      end
   end
   assign stat = stat_ff;
   assign en   = en_ff;
   assign irq  = irq_ff;
endmodule

//--- mcrr_bank.sv
// top: read-only reference readback bank with register port and interrupt
// Function
// - open-loop speed signed, negative for reverse sequence
// - open-loop speed scaled by 2^27 of max
// - open-loop torque current signed, 2^27 scaled
// - closed-loop speed signed, same scaling
// - flux current target signed, 2^27 scaled
// - torque current target signed, 2^27 scaled
// - speed-detect phase codes 0h to 6h
// - speed-detect measured speed unsigned magnitude
// - all values read zero after reset
// - position-detect phase codes 0h to Ch
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module mcrr_bank (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             irq,
   input  wire logic        eng_valid,
   input  wire logic [31:0] eng_ol_speed,
   input  wire logic [31:0] eng_ol_torque,
   input  wire logic [31:0] eng_cl_speed,
   input  wire logic [31:0] eng_flux,
   input  wire logic [31:0] eng_torque,
   input  wire logic [31:0] eng_sd_speed,
   input  wire logic [15:0] eng_sd_phase,
   input  wire logic [15:0] eng_pd_phase
);
   mcrr_upd_if upd ();
   logic [31:0] val_ff [8];
   logic [31:0] nxt_val [8];
   logic [31:0] rdata_ff, nxt_rdata;
   logic [15:0] sd_prev_ff, nxt_sd_prev, pd_prev_ff, nxt_pd_prev;
   logic [3:0]  evt, clr, stat, en;
   logic        irq_w;

   // slot number for a printed index, 8 when unmapped
   function automatic logic [3:0] slot_of(input logic [11:0] a);
      case (a)
         mcrr_pkg::IDX_OL_SPEED:  slot_of = 4'h0;
         mcrr_pkg::IDX_OL_TORQUE: slot_of = 4'h1;
         mcrr_pkg::IDX_CL_SPEED:  slot_of = 4'h2;
         mcrr_pkg::IDX_FLUX:      slot_of = 4'h3;
         mcrr_pkg::IDX_TORQUE:    slot_of = 4'h4;
         mcrr_pkg::IDX_SD_PHASE:  slot_of = 4'h5;
         mcrr_pkg::IDX_SD_SPEED:  slot_of = 4'h6;
         mcrr_pkg::IDX_PD_PHASE:  slot_of = 4'h7;
         default:                 slot_of = 4'h8;
      endcase
   endfunction

   // legal phase code checks
   function automatic logic sd_ok(input logic [15:0] p);
      sd_ok = (p <= mcrr_pkg::MCRR_SD_FAULT);
   endfunction
   function automatic logic pd_ok(input logic [15:0] p);
      pd_ok = (p <= mcrr_pkg::MCRR_PD_FAULT);
   endfunction

   mcrr_capture u_cap (
      .mclk          (mclk),
      .rst           (rst),
      .eng_valid     (eng_valid),
      .eng_ol_speed  (eng_ol_speed),
      .eng_ol_torque (eng_ol_torque),
      .eng_cl_speed  (eng_cl_speed),
      .eng_flux      (eng_flux),
      .eng_torque    (eng_torque),
      .eng_sd_speed  (eng_sd_speed),
      .eng_sd_phase  (eng_sd_phase),
      .eng_pd_phase  (eng_pd_phase),
      .upd           (upd)
   );

   // value slots follow only the engine; bus writes never reach them
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         nxt_val[i] = upd.we[i] ? upd.data[i] : val_ff[i];
      end
      // illegal phase codes are dropped, old code held
      if (upd.we[5] && !sd_ok(upd.data[5][15:0])) nxt_val[5] = val_ff[5];
      if (upd.we[7] && !pd_ok(upd.data[7][15:0])) nxt_val[7] = val_ff[7];
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) val_ff[i] <= mcrr_pkg::RST_WORD;
      end else begin
         for (int i = 0; i < 8; i++) val_ff[i] <= nxt_val[i];
      end
   end

   // detect entry into done and error phases
   always_comb begin
      nxt_sd_prev = val_ff[5][15:0];
      nxt_pd_prev = val_ff[7][15:0];
      evt = 4'h0;
      evt[mcrr_pkg::BIT_SD_DONE] = (val_ff[5][15:0] == mcrr_pkg::MCRR_SD_COMPLETE)
                                   && (sd_prev_ff != mcrr_pkg::MCRR_SD_COMPLETE);
      evt[mcrr_pkg::BIT_SD_ERR]  = (val_ff[5][15:0] == mcrr_pkg::MCRR_SD_FAULT)
                                   && (sd_prev_ff != mcrr_pkg::MCRR_SD_FAULT);
      evt[mcrr_pkg::BIT_PD_DONE] = (val_ff[7][15:0] == mcrr_pkg::MCRR_PD_COMPLETE)
                                   && (pd_prev_ff != mcrr_pkg::MCRR_PD_COMPLETE);
      evt[mcrr_pkg::BIT_PD_ERR]  = (val_ff[7][15:0] == mcrr_pkg::MCRR_PD_FAULT)
                                   && (pd_prev_ff != mcrr_pkg::MCRR_PD_FAULT);
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         sd_prev_ff <= mcrr_pkg::RST_PHASE;
         pd_prev_ff <= mcrr_pkg::RST_PHASE;
      end else begin
         sd_prev_ff <= nxt_sd_prev;
         pd_prev_ff <= nxt_pd_prev;
      end
   end

   assign clr = (wr && addr == mcrr_pkg::IDX_IRQ_CLR) ? wdata[3:0] : 4'h0;

   mcrr_irq u_irq (
      .mclk     (mclk),
      .rst      (rst),
      .evt      (evt),
      .clr      (clr),
      .en_we    (wr && addr == mcrr_pkg::IDX_IRQ_EN),
      .en_wdata (wdata[3:0]),
      .stat     (stat),
      .en       (en),
      .irq      (irq_w)
   );
   assign irq = irq_w; // registered inside u_irq

   // read data the cycle after the strobe, zero otherwise
   always_comb begin
      logic [3:0] s;
      s = slot_of(addr);
      nxt_rdata = mcrr_pkg::UNMAPPED;
      if (rd) begin
         if (s != 4'h8) begin
            nxt_rdata = val_ff[s[2:0]];
         end else if (addr == mcrr_pkg::IDX_IRQ_STAT) begin
            nxt_rdata = {28'h0000000, stat};
         end else if (addr == mcrr_pkg::IDX_IRQ_EN) begin
            nxt_rdata = {28'h0000000, en};
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) rdata_ff <= mcrr_pkg::RST_WORD;
      else     rdata_ff <= nxt_rdata;
   end
   assign rdata = rdata_ff;

   // checks
   property p_reset_zero;
      @(posedge mclk) $fell(rst) |-> (val_ff[0] == 32'h00000000 && val_ff[5] == 32'h00000000);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("bank not zero after reset");
   property p_write_no_effect;
      @(posedge mclk) disable iff (rst)
         (wr && !eng_valid && !u_cap.we_ff[0]) |=> $stable(val_ff[0]);
   endproperty
   a_write_no_effect: assert property (p_write_no_effect) else $error("write changed value");
   sequence s_olspd_cap;
      eng_valid ##2 1'b1;
   endsequence
   property p_ol_speed;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[0] == $past(eng_ol_speed, 2);
   endproperty
   a_ol_speed: assert property (p_ol_speed) else $error("open-loop speed wrong");
   property p_ol_torque;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[1] == $past(eng_ol_torque, 2);
   endproperty
   a_ol_torque: assert property (p_ol_torque) else $error("open-loop torque wrong");
   property p_cl_speed;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[2] == $past(eng_cl_speed, 2);
   endproperty
   a_cl_speed: assert property (p_cl_speed) else $error("closed-loop speed wrong");
   property p_flux;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[3] == $past(eng_flux, 2);
   endproperty
   a_flux: assert property (p_flux) else $error("flux target wrong");
   property p_torque;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[4] == $past(eng_torque, 2);
   endproperty
   a_torque: assert property (p_torque) else $error("torque target wrong");
   property p_sd_speed;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[6] == $past(eng_sd_speed, 2);
   endproperty
   a_sd_speed: assert property (p_sd_speed) else $error("detect speed wrong");
   property p_sd_range;
      @(posedge mclk) disable iff (rst) val_ff[5] <= 32'h00000006;
   endproperty
   a_sd_range: assert property (p_sd_range) else $error("speed phase out of range");
   property p_pd_range;
      @(posedge mclk) disable iff (rst) val_ff[7] <= 32'h0000000C;
   endproperty
   a_pd_range: assert property (p_pd_range) else $error("position phase out of range");

   // phase slots take a legal code two edges after the snapshot, else hold
   property p_sd_phase;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[5][15:0] ==
            (($past(eng_sd_phase, 2) <= mcrr_pkg::MCRR_SD_FAULT) ?
             $past(eng_sd_phase, 2) : $past(val_ff[5][15:0]));
   endproperty
   a_sd_phase: assert property (p_sd_phase) else $error("speed phase update wrong");
   property p_pd_phase;
      @(posedge mclk) disable iff (rst)
         s_olspd_cap |-> val_ff[7][15:0] ==
            (($past(eng_pd_phase, 2) <= mcrr_pkg::MCRR_PD_FAULT) ?
             $past(eng_pd_phase, 2) : $past(val_ff[7][15:0]));
   endproperty
   a_pd_phase: assert property (p_pd_phase) else $error("position phase update wrong");

   // read port returns the addressed slot one cycle after the strobe
   property p_rd_ol_speed;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_OL_SPEED) |=> rdata_ff == $past(val_ff[0]);
   endproperty
   a_rd_ol_speed: assert property (p_rd_ol_speed) else $error("speed read wrong");
   property p_rd_ol_torque;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_OL_TORQUE) |=> rdata_ff == $past(val_ff[1]);
   endproperty
   a_rd_ol_torque: assert property (p_rd_ol_torque) else $error("torque read wrong");
   property p_rd_cl_speed;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_CL_SPEED) |=> rdata_ff == $past(val_ff[2]);
   endproperty
   a_rd_cl_speed: assert property (p_rd_cl_speed) else $error("loop speed read wrong");
   property p_rd_flux;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_FLUX) |=> rdata_ff == $past(val_ff[3]);
   endproperty
   a_rd_flux: assert property (p_rd_flux) else $error("flux read wrong");
   property p_rd_torque;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_TORQUE) |=> rdata_ff == $past(val_ff[4]);
   endproperty
   a_rd_torque: assert property (p_rd_torque) else $error("torque target read wrong");
   property p_rd_sd_phase;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_SD_PHASE) |=> rdata_ff == $past(val_ff[5]);
   endproperty
   a_rd_sd_phase: assert property (p_rd_sd_phase) else $error("speed phase read wrong");
   property p_rd_sd_speed;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_SD_SPEED) |=> rdata_ff == $past(val_ff[6]);
   endproperty
   a_rd_sd_speed: assert property (p_rd_sd_speed) else $error("detect speed read wrong");
   property p_rd_pd_phase;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_PD_PHASE) |=> rdata_ff == $past(val_ff[7]);
   endproperty
   a_rd_pd_phase: assert property (p_rd_pd_phase) else $error("pos phase read wrong");
   // interrupt registers on the read port, zero when idle
   property p_rd_stat;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_IRQ_STAT) |=> rdata_ff == {28'h0000000, $past(stat)};
   endproperty
   a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");
   property p_rd_en;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_IRQ_EN) |=> rdata_ff == {28'h0000000, $past(en)};
   endproperty
   a_rd_en: assert property (p_rd_en) else $error("enable read wrong");
   property p_rd_clr;
      @(posedge mclk) disable iff (rst)
         (rd && addr == mcrr_pkg::IDX_IRQ_CLR) |=> rdata_ff == mcrr_pkg::UNMAPPED;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("clear register not zero");
   property p_rdata_idle;
      @(posedge mclk) disable iff (rst)
         !rd |=> rdata_ff == mcrr_pkg::UNMAPPED;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
   // sticky status: set wins over clear, clear only on request
   property p_evt_sets;
      @(posedge mclk) disable iff (rst)
         (evt != 4'h0) |=> (stat & $past(evt)) == $past(evt);
   endproperty
   a_evt_sets: assert property (p_evt_sets) else $error("event did not set status");
   property p_clr_clears;
      @(posedge mclk) disable iff (rst)
         (clr != 4'h0 && evt == 4'h0) |=> (stat & $past(clr)) == 4'h0;
   endproperty
   a_clr_clears: assert property (p_clr_clears) else $error("clear did not clear status");
   property p_stat_hold;
      @(posedge mclk) disable iff (rst)
         (clr == 4'h0 && evt == 4'h0) |=> $stable(stat);
   endproperty
   a_stat_hold: assert property (p_stat_hold) else $error("status changed on its own");
   property p_en_write;
      @(posedge mclk) disable iff (rst)
         (wr && addr == mcrr_pkg::IDX_IRQ_EN) |=> en == $past(wdata[3:0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");
   property p_irq_level;
      @(posedge mclk) disable iff (rst) irq_w == |(stat & en);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
   // entry into a done or fault phase raises its status bit next edge
   sequence s_sd_enter_done;
      (val_ff[5][15:0] != mcrr_pkg::MCRR_SD_COMPLETE) ##1
      (val_ff[5][15:0] == mcrr_pkg::MCRR_SD_COMPLETE);
   endsequence
   property p_sd_done;
      @(posedge mclk) disable iff (rst) s_sd_enter_done |=> stat[mcrr_pkg::BIT_SD_DONE];
   endproperty
   a_sd_done: assert property (p_sd_done) else $error("speed done status not set");
   sequence s_pd_enter_fault;
      (val_ff[7][15:0] != mcrr_pkg::MCRR_PD_FAULT) ##1
      (val_ff[7][15:0] == mcrr_pkg::MCRR_PD_FAULT);
   endsequence
   property p_pd_fault;
      @(posedge mclk) disable iff (rst) s_pd_enter_fault |=> stat[mcrr_pkg::BIT_PD_ERR];
   endproperty
   a_pd_fault: assert property (p_pd_fault) else $error("position error status not set");
endmodule

//--- mcrr_bank_tb_top.sv
// self-checking random bench for the reference readback bank
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); \
   end \
end
module mcrr_bank_tb_top;
   logic        mclk;
   logic        rst;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        irq;
   logic        eng_valid;
   logic [31:0] eng_w [6];
   logic [15:0] eng_sd_phase;
   logic [15:0] eng_pd_phase;
   logic [31:0] exp_v [8];
   logic [11:0] idx [8];
   int          err_count;
   int          total_checks;

   mcrr_bank dut (
      .mclk          (mclk),
      .rst           (rst),
      .addr          (addr),
      .wdata         (wdata),
      .wr            (wr),
      .rd            (rd),
      .rdata         (rdata),
      .irq           (irq),
      .eng_valid     (eng_valid),
      .eng_ol_speed  (eng_w[0]),
      .eng_ol_torque (eng_w[1]),
      .eng_cl_speed  (eng_w[2]),
      .eng_flux      (eng_w[3]),
      .eng_torque    (eng_w[4]),
      .eng_sd_speed  (eng_w[5]),
      .eng_sd_phase  (eng_sd_phase),
      .eng_pd_phase  (eng_pd_phase)
   );

   // clock, 40 ns period
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // expected phase readback: out-of-range codes keep the old value
   function automatic logic [31:0] phase_exp(logic [31:0] old, logic [15:0] nw, logic [15:0] mx);
      return (nw <= mx) ? {16'h0000, nw} : old;
   endfunction

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask

   // one engine snapshot, then wait until the bank shows it
   task automatic snap(input logic rnd, input logic [31:0] fill,
                       input logic [15:0] sp, input logic [15:0] pp);
      logic [31:0] v [6];
      for (int i = 0; i < 6; i++) begin
         v[i] = rnd ? $urandom : fill;
      end
      @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         eng_w[i] <= v[i];
      end
      eng_sd_phase <= sp;
      eng_pd_phase <= pp;
      eng_valid    <= 1'b1;
      @(posedge mclk);
      eng_valid <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 5; i++) begin
         exp_v[i] = v[i];
      end
      exp_v[6] = v[5];
      exp_v[5] = phase_exp(exp_v[5], sp, 16'h0006);
      exp_v[7] = phase_exp(exp_v[7], pp, 16'h000C);
   endtask

   // read every value slot; interrupt stays masked here
   task automatic check_all();
      for (int i = 0; i < 8; i++) begin
         rd_chk(idx[i], exp_v[i]);
      end
      `CHK(irq, 1'b0)
   endtask

   // watchdog against a hang
   initial begin
      repeat (8000) @(posedge mclk);
      err_count++;
      conclude();
   end

   // main sequence
   initial begin
      void'($urandom(32'hBFC8));
      err_count    = 0;
      total_checks = 0;
      rst          = 1'b1;
      addr         = 12'h000;
      wdata        = 32'h00000000;
      wr           = 1'b0;
      rd           = 1'b0;
      eng_valid    = 1'b0;
      eng_sd_phase = 16'h0000;
      eng_pd_phase = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         eng_w[i] = 32'h00000000;
      end
      idx = '{mcrr_pkg::IDX_OL_SPEED, mcrr_pkg::IDX_OL_TORQUE, mcrr_pkg::IDX_CL_SPEED,
              mcrr_pkg::IDX_FLUX, mcrr_pkg::IDX_TORQUE, mcrr_pkg::IDX_SD_PHASE,
              mcrr_pkg::IDX_SD_SPEED, mcrr_pkg::IDX_PD_PHASE};
      for (int i = 0; i < 8; i++) begin
         exp_v[i] = 32'h00000000;
      end
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      check_all();
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000000);
      rd_chk(12'h000, 32'h00000000);
      // sign extremes and phase range boundaries
      snap(1'b0, 32'h80000000, 16'h0006, 16'h000C);
      check_all();
      snap(1'b0, 32'hFFFFFFFF, 16'h0007, 16'h000D);
      check_all();
      snap(1'b0, 32'h7FFFFFFF, 16'h0005, 16'h000B);
      check_all();
      // random snapshots with software writes between them
      for (int n = 0; n < 24; n++) begin
         snap(1'b1, 32'h00000000, 16'($urandom % 8), 16'($urandom % 14));
         bus_wr(idx[$urandom % 8], $urandom);
         check_all();
      end
      // interrupt: raise masked, enable, clear
      snap(1'b1, 32'h00000000, 16'h0001, 16'h0001);
      bus_wr(mcrr_pkg::IDX_IRQ_CLR, 32'h0000000F);
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000000);
      snap(1'b1, 32'h00000000, 16'h0005, 16'h000C);
      repeat (2) @(posedge mclk);
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000009);
      `CHK(irq, 1'b0)
      bus_wr(mcrr_pkg::IDX_IRQ_EN, 32'h00000001);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b1)
      rd_chk(mcrr_pkg::IDX_IRQ_EN, 32'h00000001);
      bus_wr(mcrr_pkg::IDX_IRQ_CLR, 32'h00000001);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000008);
      bus_wr(mcrr_pkg::IDX_IRQ_EN, 32'h00000008);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b1)
      bus_wr(mcrr_pkg::IDX_IRQ_CLR, 32'h00000008);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      rd_chk(mcrr_pkg::IDX_IRQ_CLR, 32'h00000000);
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000000);
      // speed fault and position done set the remaining bits, both masked
      snap(1'b1, 32'h00000000, 16'h0006, 16'h000B);
      rd_chk(mcrr_pkg::IDX_IRQ_STAT, 32'h00000006);
      `CHK(irq, 1'b0)
      conclude();
   end
endmodule
